/* sdhm_encoder_model.sv */
// Behavioural safe encoder that feeds the monitor one sample per clock
`timescale 1ns/1ns
module sdhm_encoder_model
(
    // Clock
    input wire logic clk_sys_in,
    // Movement and health set by the bench
    input wire logic signed [31:0] vel_in,
    input wire logic present_in,
    input wire logic error_in,
    // Encoder sample
    output sdhm_pkg::sdhm_enc_t enc_out
);
    import sdhm_pkg::*;

    logic signed [SDHM_POS_W-1:0] position = '0;

    // Integrate velocity; position never jumps, so moves look like real travel
    always_ff @(posedge clk_sys_in)
    begin
        position <= position + vel_in;
    end

    // Speed is the magnitude only; direction shows in the position trend
    assign enc_out.present = present_in;
    assign enc_out.error = error_in;
    assign enc_out.position = position;
    assign enc_out.speed = (vel_in < 0) ? -vel_in : vel_in;
    assign enc_out.ref_pulse = 1'b0;
endmodule

/* sdhm_monitor.sv */
// Safe direction guard and safe homing monitor for one axis
`timescale 1ns/1ns
module sdhm_monitor #(
    parameter int CYCLE_CLKS = sdhm_pkg::SDHM_CYCLE_CLKS
)(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Requests, confirmation and home switch
    input wire logic req_positive_direction_guard_in,
    input wire logic req_negative_direction_guard_in,
    input wire logic homing_request_in,
    input wire logic error_confirm_in,
    input wire logic home_switch_input_in,
    // Encoder and configuration
    input wire sdhm_pkg::sdhm_enc_t enc_in,
    input wire sdhm_pkg::sdhm_cfg_t cfg_in,
    // Status
    output logic no_functional_error_out,
    output logic torque_enable_out,
    output logic direction_guard_ok_out,
    output logic position_trusted_flag_out,
    output logic homing_busy_out,
    output logic power_cycle_fault_out,
    output logic signed [sdhm_pkg::SDHM_POS_W-1:0] actual_position_out
);
    import sdhm_pkg::*;

    initial
    begin
        if (CYCLE_CLKS < 1)
        begin
            $error("CYCLE_CLKS must be at least 1");
        end
    end

    typedef enum logic [1:0] {SDHM_DIR_IDLE, SDHM_DIR_WAIT, SDHM_DIR_ACTIVE} sdhm_dir_t;
    typedef enum logic [1:0] {SDHM_H_IDLE, SDHM_H_RUN, SDHM_H_DONE} sdhm_hst_t;

    // Magnitude of a signed difference
    function automatic logic [SDHM_POS_W-1:0] sdhm_abs(input logic signed [SDHM_POS_W-1:0] v);
        sdhm_abs = v[SDHM_POS_W-1] ? SDHM_POS_W'(-v) : SDHM_POS_W'(v);
    endfunction

    // Synchronised pins (pins arrive from outside)
    logic [1:0] s_pos, s_neg, s_home, s_conf, s_sw;
    logic pos_q, neg_q, home_q, conf_q, sw_q;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            s_pos <= 2'h0;
            s_neg <= 2'h0;
            s_home <= 2'h0;
            s_conf <= 2'h0;
            s_sw <= 2'h0;
        end
        else
        begin
            s_pos <= {s_pos[0], req_positive_direction_guard_in};
            s_neg <= {s_neg[0], req_negative_direction_guard_in};
            s_home <= {s_home[0], homing_request_in};
            s_conf <= {s_conf[0], error_confirm_in};
            s_sw <= {s_sw[0], home_switch_input_in};
        end
    end
    assign pos_q = s_pos[1];
    assign neg_q = s_neg[1];
    assign home_q = s_home[1];
    assign conf_q = s_conf[1];
    assign sw_q = s_sw[1];

    // Safety cycle tick; everything below except the output registers advances only on it
    logic [SDHM_CNT_W-1:0] cyc_cnt;
    logic tick;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            cyc_cnt <= '0;
            tick <= 1'b0;
        end
        else if (cyc_cnt == SDHM_CNT_W'(CYCLE_CLKS - 1))
        begin
            cyc_cnt <= '0;
            tick <= 1'b1;
        end
        else
        begin
            cyc_cnt <= cyc_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    // Sampled copies held per safety cycle, so all monitors see one snapshot
    logic pos_r, neg_r, home_r, home_prev, sw_r, sw_prev, conf_r;
    sdhm_enc_t enc_r;
    logic signed [SDHM_POS_W-1:0] pos_prev;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            pos_r <= 1'b0;
            neg_r <= 1'b0;
            home_r <= 1'b0;
            home_prev <= 1'b0;
            sw_r <= 1'b0;
            sw_prev <= 1'b0;
            conf_r <= 1'b0;
            enc_r <= '0;
            pos_prev <= '0;
        end
        else if (tick)
        begin
            pos_r <= pos_q;
            neg_r <= neg_q;
            home_prev <= home_r;
            home_r <= home_q;
            sw_prev <= sw_r;
            sw_r <= sw_q;
            conf_r <= conf_q;
            pos_prev <= enc_r.position;
            enc_r <= enc_in;
        end
    end

    logic enc_good;
    logic home_rise;
    logic signed [SDHM_POS_W-1:0] delta;
    assign enc_good = enc_r.present && !enc_r.error;
    assign home_rise = home_r && !home_prev;
    assign delta = enc_r.position - pos_prev;

    // Direction guard: request, delay, active with slave pointer
    sdhm_dir_t dir_st;
    logic [SDHM_CNT_W-1:0] dir_cnt;
    logic dir_neg;
    logic signed [SDHM_POS_W-1:0] ref_ptr;
    logic dir_violate, dir_enc_fail;
    logic dir_req;
    assign dir_req = pos_r || neg_r;
    // Forbidden distance measured from the furthest permitted point
    logic signed [SDHM_POS_W-1:0] back_dist;
    assign back_dist = dir_neg ? enc_r.position - ref_ptr : ref_ptr - enc_r.position;
    always_comb
    begin
        dir_violate = 1'b0;
        dir_enc_fail = 1'b0;
        if (dir_st != SDHM_DIR_IDLE && dir_req && !enc_good)
        begin
            dir_enc_fail = 1'b1;
        end
        if (dir_st == SDHM_DIR_ACTIVE && !back_dist[SDHM_POS_W-1]
            && back_dist > $signed(cfg_in.position_tolerance))
        begin
            dir_violate = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            dir_st <= SDHM_DIR_IDLE;
            dir_cnt <= '0;
            dir_neg <= 1'b0;
            ref_ptr <= '0;
        end
        else if (tick)
        begin
            // Runs whatever other monitors do; nothing here gates on them
            unique case (dir_st)
                SDHM_DIR_IDLE:
                begin
                    if (dir_req)
                    begin
                        dir_neg <= neg_r && !pos_r;
                        dir_cnt <= '0;
                        dir_st <= SDHM_DIR_WAIT;
                    end
                end
                SDHM_DIR_WAIT:
                begin
                    if (!dir_req)
                    begin
                        dir_st <= SDHM_DIR_IDLE;
                    end
                    else if (dir_cnt >= cfg_in.direction_start_delay)
                    begin
                        ref_ptr <= enc_r.position;
                        dir_st <= SDHM_DIR_ACTIVE;
                    end
                    else
                    begin
                        dir_cnt <= dir_cnt + SDHM_CNT_W'(SDHM_CYCLE_US);
                    end
                end
                SDHM_DIR_ACTIVE:
                begin
                    if (!dir_req)
                    begin
                        dir_st <= SDHM_DIR_IDLE;
                    end
                    else if (back_dist[SDHM_POS_W-1])
                    begin
                        ref_ptr <= enc_r.position;
                    end
                end
                default:
                begin
                    dir_st <= SDHM_DIR_IDLE;
                end
            endcase
        end
    end

    // Homing sequencer
    sdhm_hst_t h_st;
    logic [SDHM_CNT_W-1:0] h_cnt;
    logic blk_on;
    logic signed [SDHM_POS_W-1:0] blk_start;
    logic h_enc_fail, h_timeout, in_dir, slow_ok, sw_edge, pulse_ok, h_done;
    logic signed [SDHM_POS_W-1:0] trusted_pos;
    assign h_enc_fail = (home_rise || h_st == SDHM_H_RUN) && home_r && !enc_good;
    assign h_timeout = h_st == SDHM_H_RUN && h_cnt >= cfg_in.homing_timeout;
    // Direction of travel this cycle, judged against the trigger direction
    assign in_dir = cfg_in.trigger_negative ? delta[SDHM_POS_W-1]
        : (!delta[SDHM_POS_W-1] && delta != '0);
    assign slow_ok = enc_r.speed <= cfg_in.max_trigger_speed;
    // Edge sense is fixed to positive travel, so negative travel sees the raw change inverted
    assign sw_edge = ((cfg_in.switch_edge_negative ^ cfg_in.trigger_negative)
        ? (sw_prev && !sw_r) : (!sw_prev && sw_r))
        && in_dir && slow_ok;
    assign pulse_ok = enc_r.ref_pulse && in_dir && slow_ok
        && !(blk_on && sdhm_abs(enc_r.position - blk_start) < cfg_in.blocking_distance);
    always_comb
    begin
        h_done = 1'b0;
        if (h_st == SDHM_H_RUN && home_r)
        begin
            unique case (cfg_in.mode)
                SDHM_HOME_DIRECT: h_done = 1'b1;
                SDHM_HOME_SWITCH: h_done = cfg_in.ref_pulse_used ? pulse_ok && blk_on : sw_edge;
                SDHM_HOME_OFFSET, SDHM_HOME_OFFSET_CORR:
                    h_done = cfg_in.ref_pulse_used ? pulse_ok : sw_edge;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            h_st <= SDHM_H_IDLE;
            h_cnt <= '0;
            blk_on <= 1'b0;
            blk_start <= '0;
            trusted_pos <= '0;
        end
        else if (tick)
        begin
            unique case (h_st)
                SDHM_H_IDLE:
                begin
                    if (home_rise)
                    begin
                        h_cnt <= '0;
                        blk_on <= 1'b0;
                        h_st <= SDHM_H_RUN;
                    end
                end
                SDHM_H_RUN:
                begin
                    h_cnt <= h_cnt + SDHM_CNT_W'(SDHM_CYCLE_US);
                    if (!home_r || h_timeout)
                    begin
                        h_st <= SDHM_H_IDLE;
                    end
                    else if (h_done)
                    begin
                        trusted_pos <= cfg_in.home_position;
                        h_st <= SDHM_H_DONE;
                    end
                    else if (sw_edge && cfg_in.ref_pulse_used && !blk_on)
                    begin
                        blk_on <= 1'b1;
                        blk_start <= enc_r.position;
                    end
                end
                SDHM_H_DONE:
                begin
                    if (!home_r)
                    begin
                        h_st <= SDHM_H_IDLE;
                    end
                end
                default:
                begin
                    h_st <= SDHM_H_IDLE;
                end
            endcase
        end
    end

    // Fail-safe latches; functional one needs confirmation, the other a power cycle
    logic func_fail, hard_fail;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            func_fail <= 1'b0;
            hard_fail <= 1'b0;
        end
        else if (tick)
        begin
            if (h_enc_fail)
            begin
                hard_fail <= 1'b1;
            end
            // A new fault in the confirm cycle wins over the confirm
            if (dir_violate || dir_enc_fail || h_timeout)
            begin
                func_fail <= 1'b1;
            end
            else if (conf_r)
            begin
                func_fail <= 1'b0;
            end
        end
    end

    // Trusted latch outlives the request; dropping it after completion keeps the position
    logic homed;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            homed <= SDHM_TRUSTED_RST;
        end
        else if (tick)
        begin
            if (h_st == SDHM_H_IDLE && home_rise)
            begin
                homed <= 1'b0;
            end
            else if (h_st == SDHM_H_RUN && !h_timeout && h_done)
            begin
                homed <= 1'b1;
            end
        end
    end

    // Outputs, all registered
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            no_functional_error_out <= SDHM_NOERR_RST;
            torque_enable_out <= SDHM_TORQUE_RST;
            direction_guard_ok_out <= 1'b0;
            position_trusted_flag_out <= SDHM_TRUSTED_RST;
            homing_busy_out <= 1'b0;
            power_cycle_fault_out <= 1'b0;
            actual_position_out <= '0;
        end
        else
        begin
            no_functional_error_out <= !func_fail;
            torque_enable_out <= !func_fail && !hard_fail;
            direction_guard_ok_out <= dir_st == SDHM_DIR_ACTIVE && !func_fail;
            position_trusted_flag_out <= homed && enc_good;
            homing_busy_out <= h_st == SDHM_H_RUN;
            power_cycle_fault_out <= hard_fail;
            actual_position_out <= enc_r.position - pos_prev + trusted_pos;
        end
    end

    // Checks
    a_violation_trips: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        tick && dir_violate |=> ##1 !no_functional_error_out && !torque_enable_out)
        else $error("direction violation did not trip");
    a_trusted_after_rise: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        tick && home_rise |=> ##1 !position_trusted_flag_out)
        else $error("trusted flag not cleared on homing start");
    a_hard_latched: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        power_cycle_fault_out |=> power_cycle_fault_out)
        else $error("power cycle fault released");
    a_abort_homing: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        tick && h_st == SDHM_H_RUN && !home_r |=> h_st == SDHM_H_IDLE)
        else $error("homing not aborted");
    a_timeout_fails: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        tick && h_timeout |=> func_fail)
        else $error("homing timeout did not fail");
    a_guard_ok_state: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        direction_guard_ok_out |-> $past(dir_st) == SDHM_DIR_ACTIVE)
        else $error("guard ok without active guard");
    a_enc_fail_dir: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        tick && dir_enc_fail |=> func_fail)
        else $error("encoder fault not tripped");
    a_pointer_follow: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        tick && dir_st == SDHM_DIR_ACTIVE && dir_req && back_dist[SDHM_POS_W-1]
        |=> ref_ptr == $past(enc_r.position))
        else $error("pointer did not follow");
endmodule

/* sdhm_pkg.sv */
// Shared constants and carrier types for the direction guard and homing monitor
package sdhm_pkg;

    // Widths
    localparam int SDHM_POS_W = 32;
    localparam int SDHM_CNT_W = 32;

    // Clock rate and timing
    localparam int SDHM_CLK_MHZ = 125;
    localparam int SDHM_DIR_DELAY_US_DEF = 0;
    localparam int SDHM_HOME_TMO_US_DEF = 0;
    localparam int SDHM_CYCLE_US = 1;
    localparam int SDHM_CYCLE_CLKS = SDHM_CYCLE_US * SDHM_CLK_MHZ;

    // Reset values
    localparam logic SDHM_TRUSTED_RST = 1'b0;
    localparam logic SDHM_NOERR_RST = 1'b1;
    localparam logic SDHM_TORQUE_RST = 1'b0;

    // Homing modes
    typedef enum logic [1:0]
    {
        SDHM_HOME_DIRECT = 2'h0,
        SDHM_HOME_SWITCH = 2'h1,
        SDHM_HOME_OFFSET = 2'h2,
        SDHM_HOME_OFFSET_CORR = 2'h3
    } sdhm_mode_t;

    // Encoder sample
    typedef struct packed
    {
        logic present;
        logic error;
        logic signed [SDHM_POS_W-1:0] position;
        logic [SDHM_POS_W-1:0] speed;
        logic ref_pulse;
    } sdhm_enc_t;

    // Configuration
    typedef struct packed
    {
        logic [SDHM_POS_W-1:0] position_tolerance;
        logic [SDHM_CNT_W-1:0] direction_start_delay;
        logic [SDHM_CNT_W-1:0] homing_timeout;
        logic signed [SDHM_POS_W-1:0] home_position;
        logic [SDHM_POS_W-1:0] max_trigger_speed;
        logic [SDHM_POS_W-1:0] blocking_distance;
        sdhm_mode_t mode;
        logic switch_edge_negative;
        logic trigger_negative;
        logic ref_pulse_used;
    } sdhm_cfg_t;

endpackage

/* tb_top.sv */
// Self-checking bench for the direction guard and homing monitor
`timescale 1ns/1ns
module tb_top;
    import sdhm_pkg::*;

    localparam int LIMIT = 20000;
    localparam int SETTLE = 24;

    typedef struct
    {
        logic pos;
        logic neg;
        logic err;
        int d1;
        int d2;
        logic fail;
    } sdhm_row_t;

    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req_pos = 1'b0;
    logic req_neg = 1'b0;
    logic home_req = 1'b0;
    logic confirm = 1'b0;
    logic sw = 1'b0;
    logic signed [31:0] vel = '0;
    logic enc_err = 1'b0;
    logic enc_present = 1'b1;
    sdhm_enc_t enc;
    sdhm_cfg_t cfg;
    logic no_err;
    logic torque;
    logic dir_ok;
    logic trusted;
    logic busy;
    logic pc_fault;
    logic signed [31:0] act_pos;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    sdhm_row_t rows [8];

    // Clock at 8 ns period
    always #4 clk_sys_in = ~clk_sys_in;

    sdhm_encoder_model enc_model
    (
        .clk_sys_in(clk_sys_in),
        .vel_in(vel),
        .present_in(enc_present),
        .error_in(enc_err),
        .enc_out(enc)
    );

    // Short safety cycle keeps delays and timeouts in a few clocks
    sdhm_monitor #(.CYCLE_CLKS(4)) uut
    (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .req_positive_direction_guard_in(req_pos),
        .req_negative_direction_guard_in(req_neg),
        .homing_request_in(home_req),
        .error_confirm_in(confirm),
        .home_switch_input_in(sw),
        .enc_in(enc),
        .cfg_in(cfg),
        .no_functional_error_out(no_err),
        .torque_enable_out(torque),
        .direction_guard_ok_out(dir_ok),
        .position_trusted_flag_out(trusted),
        .homing_busy_out(busy),
        .power_cycle_fault_out(pc_fault),
        .actual_position_out(act_pos)
    );

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            err_total++;
            test_done();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask

    task automatic do_reset();
        rst_n_in = 1'b0;
        cyc(10);
        rst_n_in = 1'b1;
        cyc(2);
    endtask

    // Travel d units over ten clocks, then stand still
    task automatic move(input int d);
        vel = d / 10;
        cyc(10);
        vel = '0;
        cyc(SETTLE);
    endtask

    task automatic pulse_confirm();
        confirm = 1'b1;
        cyc(SETTLE);
        confirm = 1'b0;
        cyc(SETTLE);
    endtask

    initial
    begin
        cfg = '0;
        cfg.position_tolerance = 32'h0000_000a;
        cfg.homing_timeout = 32'h0000_0028;
        cfg.home_position = 32'h0000_03e8;
        cfg.max_trigger_speed = 32'h0000_0005;
        cfg.mode = SDHM_HOME_DIRECT;
        // Direction rows: requests, encoder error, two moves, trip expected
        rows[0] = '{1'b1, 1'b0, 1'b0, 100, 0, 1'b0};
        rows[1] = '{1'b1, 1'b0, 1'b0, -10, 0, 1'b0};
        rows[2] = '{1'b1, 1'b0, 1'b0, -20, 0, 1'b1};
        rows[3] = '{1'b1, 1'b0, 1'b0, 100, -20, 1'b1};
        rows[4] = '{1'b0, 1'b1, 1'b0, -100, 0, 1'b0};
        rows[5] = '{1'b0, 1'b1, 1'b0, 20, 0, 1'b1};
        rows[6] = '{1'b1, 1'b1, 1'b0, -20, 0, 1'b1};
        rows[7] = '{1'b0, 1'b1, 1'b1, 0, 0, 1'b1};
        cyc(1);
        foreach (rows[i])
        begin
            do_reset();
            enc_err = rows[i].err;
            req_pos = rows[i].pos;
            req_neg = rows[i].neg;
            cyc(SETTLE);
            check("guard_ok_start", dir_ok, !rows[i].err);
            move(rows[i].d1);
            move(rows[i].d2);
            check("no_err", no_err, !rows[i].fail);
            check("guard_ok", dir_ok, !rows[i].fail);
            if (rows[i].fail)
                check("torque", torque, 1'b0);
            req_pos = 1'b0;
            req_neg = 1'b0;
            enc_err = 1'b0;
        end
        // Latched trip survives dropped request until confirmed
        cyc(SETTLE);
        check("latched", no_err, 1'b0);
        pulse_confirm();
        check("confirmed", no_err, 1'b1);
        // Start-up state
        do_reset();
        check("rst_no_err", no_err, 1'b1);
        check("rst_trusted", trusted, 1'b0);
        check("rst_busy", busy, 1'b0);
        check("rst_pcf", pc_fault, 1'b0);
        check("rst_ok", dir_ok, 1'b0);
        // Direct homing loads the home position, switch ignored
        sw = 1'b1;
        home_req = 1'b1;
        cyc(SETTLE);
        check("direct_trusted", trusted, 1'b1);
        check("direct_pos", act_pos, 32'h0000_03e8);
        home_req = 1'b0;
        sw = 1'b0;
        cyc(SETTLE);
        check("trusted_kept", trusted, 1'b1);
        // Switch mode: edge clears trusted, fast pass ignored, slow pass homes
        cfg.mode = SDHM_HOME_SWITCH;
        home_req = 1'b1;
        cyc(SETTLE);
        check("edge_clears", trusted, 1'b0);
        check("busy", busy, 1'b1);
        vel = 10;
        cyc(8);
        sw = 1'b1;
        cyc(SETTLE);
        check("fast_ignored", busy, 1'b1);
        sw = 1'b0;
        vel = -2;
        cyc(8);
        sw = 1'b1;
        cyc(SETTLE);
        check("wrong_dir", busy, 1'b1);
        sw = 1'b0;
        vel = 2;
        cyc(8);
        sw = 1'b1;
        cyc(SETTLE);
        check("slow_homed", trusted, 1'b1);
        vel = '0;
        sw = 1'b0;
        home_req = 1'b0;
        cyc(SETTLE);
        // Abort: dropped request stops the timer as well
        home_req = 1'b1;
        cyc(SETTLE);
        home_req = 1'b0;
        cyc(200);
        check("abort_busy", busy, 1'b0);
        check("abort_no_err", no_err, 1'b1);
        check("abort_trusted", trusted, 1'b0);
        // Timeout trips the functional fail-safe
        home_req = 1'b1;
        cyc(200);
        check("tmo_no_err", no_err, 1'b0);
        check("tmo_torque", torque, 1'b0);
        home_req = 1'b0;
        pulse_confirm();
        check("tmo_confirm", no_err, 1'b1);
        // Encoder fault during homing needs a power cycle
        enc_err = 1'b1;
        home_req = 1'b1;
        cyc(SETTLE);
        home_req = 1'b0;
        enc_err = 1'b0;
        pulse_confirm();
        check("pcf_latched", pc_fault, 1'b1);
        check("pcf_torque", torque, 1'b0);
        do_reset();
        check("pcf_cleared", pc_fault, 1'b0);
        // Guard requested with no encoder present trips at once
        enc_present = 1'b0;
        req_neg = 1'b1;
        cyc(SETTLE);
        check("absent_no_err", no_err, 1'b0);
        req_neg = 1'b0;
        enc_present = 1'b1;
        pulse_confirm();
        check("absent_confirm", no_err, 1'b1);
        // Start delay in safety cycles, then guard runs beside homing
        cfg.direction_start_delay = 32'h0000_0005;
        cfg.mode = SDHM_HOME_DIRECT;
        req_pos = 1'b1;
        cyc(12);
        check("delay_wait", dir_ok, 1'b0);
        cyc(36);
        check("delay_done", dir_ok, 1'b1);
        home_req = 1'b1;
        cyc(SETTLE);
        check("both_trusted", trusted, 1'b1);
        check("both_ok", dir_ok, 1'b1);
        home_req = 1'b0;
        req_pos = 1'b0;
        cyc(4);
        test_done();
    end
endmodule
